// file: logic/rcl_pkg.sv
// Types shared by the reset-cause and pre-divider block
package rcl_pkg;
  typedef enum logic [1:0] {
    LSI_OFF,
    LSI_START,
    LSI_ON,
    LSI_STOP
  } rcl_lsi_e;
  typedef logic [5:0] rcl_flags_t;
endpackage : rcl_pkg

// file: logic/rcl_regs.svh
// Register offsets, field positions, reset values and counts of the block
`ifndef RCL_REGS_SVH
`define RCL_REGS_SVH
`define RCL_CSR_OFF 12'h024
`define RCL_CFGR2_OFF 12'h02C
`define RCL_IRQ_STAT_OFF 12'h030
`define RCL_IRQ_MASK_OFF 12'h034
`define RCL_CSR_RST 32'h0C00_0000
`define RCL_FLAGS_POR 6'h03
`define RCL_FLAG_LSB 26
`define RCL_FLAG_CLR_BIT 24
`define RCL_RDY_BIT 1
`define RCL_LSI_EN_BIT 0
`define RCL_PREDIV_RST 4'h0
`define RCL_IRQ_RST 2'h0
`define RCL_LSI_STOP_TICKS 8'h03
`define RCL_CSR_RMASK 32'h02FF_FFFC
`endif

// file: logic/rcl_top.sv
// Reset-cause flags, low-speed oscillator control and PLL pre-divider
`timescale 1ns/1ps
`include "rcl_regs.svh"
module rcl_top #(
  parameter int LSI_STARTUP_TICKS = 16
) (
  input wire logic core_clk_in,
  input wire logic rst_in,
  input wire logic por_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [11:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  input wire logic [3:0] pstrb_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  input wire logic lowpower_reset_in,
  input wire logic window_watchdog_reset_in,
  input wire logic independent_watchdog_reset_in,
  input wire logic software_reset_in,
  input wire logic power_on_down_reset_in,
  input wire logic external_reset_pin_in,
  input wire logic lsi_tick_in,
  input wire logic pll_enabled_in,
  input wire logic cfg_bit17_wr_in,
  input wire logic cfg_bit17_val_in,
  input wire logic pll_ref_tick_in,
  output logic lsi_enable_out,
  output logic lsi_ready_out,
  output logic [3:0] prediv_out,
  output logic prediv_tick_out,
  output logic irq_out
);

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  function automatic logic hit(input logic [11:0] a, input logic [11:0] o);
    hit = (a[11:2] == o[11:2]);
  endfunction : hit

  function automatic logic [7:0] lane(input logic [31:0] d,
                                      input logic [1:0] n);
    lane = d[8*n +: 8];
  endfunction : lane

  logic sys_rst;
  logic setup;
  logic access;
  logic done;
  logic wr_go;
  logic rd_go;
  logic csr_hit;
  logic cfg_hit;
  logic stat_hit;
  logic mask_hit;
  logic mapped;
  logic [31:0] rd_mux;
  rcl_pkg::rcl_flags_t evt;
  rcl_pkg::rcl_flags_t flags_r;
  logic flag_removal_bit_r;
  logic lsi_en_r;
  logic lsi_ready_r;
  logic lsi_ready_q;
  rcl_pkg::rcl_lsi_e lsi_state_r;
  logic [7:0] lsi_cnt_r;
  logic [3:0] prediv_r;
  logic [3:0] div_cnt_r;
  logic prediv_tick_r;
  logic [1:0] irq_stat_r;
  logic [1:0] irq_mask_r;
  logic [1:0] irq_evt;
  logic irq_r;
  logic pready_r;
  logic pslverr_r;
  logic [31:0] prdata_r;
  logic last_csr_r;

  // Power reset is also a system reset
  assign sys_rst = rst_in | por_in;
  assign setup = psel_in & ~penable_in;
  assign access = psel_in & penable_in;
  assign done = access & pready_r;
  assign wr_go = done & pwrite_in;
  assign rd_go = done & ~pwrite_in;
  assign csr_hit = hit(paddr_in, `RCL_CSR_OFF);
  assign cfg_hit = hit(paddr_in, `RCL_CFGR2_OFF);
  assign stat_hit = hit(paddr_in, `RCL_IRQ_STAT_OFF);
  assign mask_hit = hit(paddr_in, `RCL_IRQ_MASK_OFF);
  assign mapped = csr_hit | cfg_hit | stat_hit | mask_hit;

  // ---------------------------------------------------------------
  // Reset-cause flags
  // ---------------------------------------------------------------
  assign evt = {lowpower_reset_in,
                window_watchdog_reset_in,
                independent_watchdog_reset_in,
                software_reset_in,
                power_on_down_reset_in,
                external_reset_pin_in};

  // Survive rst_in but not power reset; a new cause beats the removal clear
  always_ff @(posedge core_clk_in) begin
    if (por_in) begin
      flags_r <= `RCL_FLAGS_POR;
    end else if (flag_removal_bit_r) begin
      flags_r <= evt;
    end else begin
      flags_r <= flags_r | evt;
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (sys_rst) begin
      flag_removal_bit_r <= 1'b0;
    end else if (wr_go && csr_hit && pstrb_in[3]) begin
      flag_removal_bit_r <= pwdata_in[`RCL_FLAG_CLR_BIT];
    end
  end

  // ---------------------------------------------------------------
  // Low-speed oscillator enable and ready
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk_in) begin
    if (sys_rst) begin
      lsi_en_r <= 1'b0;
    end else if (wr_go && csr_hit && pstrb_in[0]) begin
      lsi_en_r <= pwdata_in[`RCL_LSI_EN_BIT];
    end
  end

  // Ready only moves on oscillator ticks; re-enable during stop keeps it
  always_ff @(posedge core_clk_in) begin
    if (sys_rst) begin
      lsi_state_r <= rcl_pkg::LSI_OFF;
      lsi_cnt_r <= 8'h00;
      lsi_ready_r <= 1'b0;
    end else begin
      case (lsi_state_r)
        rcl_pkg::LSI_OFF: begin
          lsi_cnt_r <= 8'h00;
          if (lsi_en_r) begin
            lsi_state_r <= rcl_pkg::LSI_START;
          end
        end
        rcl_pkg::LSI_START: begin
          if (!lsi_en_r) begin
            lsi_state_r <= rcl_pkg::LSI_OFF;
          end else if (lsi_tick_in) begin
            if (lsi_cnt_r >= 8'(LSI_STARTUP_TICKS - 1)) begin
              lsi_state_r <= rcl_pkg::LSI_ON;
              lsi_ready_r <= 1'b1;
              lsi_cnt_r <= 8'h00;
            end else begin
              lsi_cnt_r <= lsi_cnt_r + 8'h01;
            end
          end
        end
        rcl_pkg::LSI_ON: begin
          lsi_cnt_r <= 8'h00;
          if (!lsi_en_r) begin
            lsi_state_r <= rcl_pkg::LSI_STOP;
          end
        end
        rcl_pkg::LSI_STOP: begin
          if (lsi_en_r) begin
            lsi_state_r <= rcl_pkg::LSI_ON;
          end else if (lsi_tick_in) begin
            if (lsi_cnt_r == `RCL_LSI_STOP_TICKS - 8'h01) begin
              lsi_state_r <= rcl_pkg::LSI_OFF;
              lsi_ready_r <= 1'b0;
            end else begin
              lsi_cnt_r <= lsi_cnt_r + 8'h01;
            end
          end
        end
        default: begin
          lsi_state_r <= rcl_pkg::LSI_OFF;
          lsi_ready_r <= 1'b0;
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // PLL input pre-divider
  // ---------------------------------------------------------------
  // Shared bit 0: a main-config write lands after a bus write
  always_ff @(posedge core_clk_in) begin
    if (sys_rst) begin
      prediv_r <= `RCL_PREDIV_RST;
    end else begin
      if (wr_go && cfg_hit && pstrb_in[0] && !pll_enabled_in) begin
        prediv_r <= pwdata_in[3:0];
      end
      if (cfg_bit17_wr_in && !pll_enabled_in) begin
        prediv_r[0] <= cfg_bit17_val_in;
      end
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (sys_rst) begin
      div_cnt_r <= 4'h0;
      prediv_tick_r <= 1'b0;
    end else begin
      prediv_tick_r <= 1'b0;
      if (pll_ref_tick_in) begin
        if (div_cnt_r >= prediv_r) begin
          div_cnt_r <= 4'h0;
          prediv_tick_r <= 1'b1;
        end else begin
          div_cnt_r <= div_cnt_r + 4'h1;
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // Interrupts: ready rise and ready fall
  // ---------------------------------------------------------------
  assign irq_evt = {lsi_ready_q & ~lsi_ready_r, lsi_ready_r & ~lsi_ready_q};

  always_ff @(posedge core_clk_in) begin
    if (sys_rst) begin
      lsi_ready_q <= 1'b0;
      irq_stat_r <= `RCL_IRQ_RST;
      irq_mask_r <= `RCL_IRQ_RST;
      irq_r <= 1'b0;
    end else begin
      lsi_ready_q <= lsi_ready_r;
      irq_r <= |(irq_stat_r & irq_mask_r);
      if (rd_go && stat_hit) begin
        // Clear only what the read reported, so no late event is lost
        irq_stat_r <= (irq_stat_r & ~prdata_r[1:0]) | irq_evt;
      end else begin
        irq_stat_r <= irq_stat_r | irq_evt;
      end
      if (wr_go && mask_hit && pstrb_in[0]) begin
        irq_mask_r <= pwdata_in[1:0];
      end
    end
  end

  // ---------------------------------------------------------------
  // APB slave
  // ---------------------------------------------------------------
  always_comb begin
    rd_mux = 32'h0000_0000;
    if (csr_hit) begin
      rd_mux[31:`RCL_FLAG_LSB] = flags_r;
      rd_mux[`RCL_FLAG_CLR_BIT] = flag_removal_bit_r;
      rd_mux[`RCL_RDY_BIT] = lsi_ready_r;
      rd_mux[`RCL_LSI_EN_BIT] = lsi_en_r;
    end else if (cfg_hit) begin
      rd_mux[3:0] = prediv_r;
    end else if (stat_hit) begin
      rd_mux[1:0] = irq_stat_r;
    end else if (mask_hit) begin
      rd_mux[1:0] = irq_mask_r;
    end
  end

  // Back-to-back status accesses take one wait state, others none
  always_ff @(posedge core_clk_in) begin
    if (sys_rst) begin
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r <= 32'h0000_0000;
    end else begin
      if (setup) begin
        pready_r <= ~(csr_hit & last_csr_r);
      end else if (access && !pready_r) begin
        pready_r <= 1'b1;
      end else begin
        pready_r <= 1'b0;
      end
      if (setup || (access && !pready_r)) begin
        prdata_r <= rd_mux;
        pslverr_r <= ~mapped;
      end else if (done) begin
        pslverr_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (sys_rst) begin
      last_csr_r <= 1'b0;
    end else if (done) begin
      last_csr_r <= csr_hit;
    end
  end

  assign prdata_out = prdata_r;
  assign pready_out = pready_r;
  assign pslverr_out = pslverr_r;
  assign lsi_enable_out = lsi_en_r;
  assign lsi_ready_out = lsi_ready_r;
  assign prediv_out = prediv_r;
  assign prediv_tick_out = prediv_tick_r;
  assign irq_out = irq_r;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (sys_rst);

  // Oscillator ticks counted apart from the state machine after a clear
  logic stop_armed_r;
  logic [7:0] stop_seen_r;

  always_ff @(posedge core_clk_in) begin
    if (sys_rst || lsi_en_r || !lsi_ready_r) begin
      stop_armed_r <= 1'b0;
      stop_seen_r <= 8'h00;
    end else begin
      stop_armed_r <= 1'b1;
      if (stop_armed_r && lsi_tick_in) begin
        stop_seen_r <= stop_seen_r + 8'h01;
      end
    end
  end

  a_lpwr_flag_set: assert property (evt[5] |=> flags_r[5])
    else $error("low-power flag not set");
  a_wwdg_flag_set: assert property (evt[4] |=> flags_r[4])
    else $error("window watchdog flag not set");
  a_iwdg_flag_set: assert property (evt[3] |=> flags_r[3])
    else $error("independent watchdog flag not set");
  a_sw_flag_set: assert property (evt[2] |=> flags_r[2])
    else $error("software flag not set");
  a_por_flag_set: assert property (evt[1] |=> flags_r[1])
    else $error("power flag not set");
  a_pin_flag_set: assert property (evt[0] |=> flags_r[0])
    else $error("pin flag not set");
  a_flags_removed: assert property (
    flag_removal_bit_r && evt == 6'h00 |=> flags_r == 6'h00)
    else $error("flags not removed");
  a_ready_holds: assert property (
    stop_armed_r && lsi_ready_r &&
    !(lsi_tick_in && stop_seen_r == `RCL_LSI_STOP_TICKS - 8'h01)
    |=> lsi_ready_r)
    else $error("ready fell early");
  a_ready_falls: assert property (
    stop_armed_r && lsi_ready_r && !lsi_en_r && lsi_tick_in &&
    stop_seen_r == `RCL_LSI_STOP_TICKS - 8'h01 |=> !lsi_ready_r)
    else $error("ready did not fall on third tick");
  a_prediv_locked: assert property (
    pll_enabled_in |=> $stable(prediv_r))
    else $error("pre-divider changed while PLL on");
  a_cfg_no_wait: assert property (
    setup && cfg_hit |=> pready_r)
    else $error("pre-divider access waited");
  a_csr_wait_max: assert property (
    setup && csr_hit |-> ##[1:2] pready_r)
    else $error("status access too slow");
  a_resv_zero: assert property (
    done && csr_hit |-> (prdata_r & `RCL_CSR_RMASK) == 32'h0)
    else $error("reserved bits nonzero");
  a_div_undiv: assert property (
    pll_ref_tick_in && prediv_r == 4'h0 |=> prediv_tick_r)
    else $error("undivided tick missing");

  c_flag_clear: cover property (flag_removal_bit_r ##1 flags_r == 6'h00);
  c_lsi_ready: cover property ($rose(lsi_ready_r));
  c_lsi_stop: cover property ($fell(lsi_ready_r));
  c_csr_wait: cover property (access && !pready_r && csr_hit);
  c_prediv_refused: cover property (wr_go && cfg_hit && pll_enabled_in);

endmodule : rcl_top

// file: test/rcl_top_bench.sv
// Self-checking bench for the reset-cause and pre-divider block
`timescale 1ns/1ps
`include "rcl_regs.svh"
module rcl_top_bench;
  // ----------------------------------------
  // Stimulus and observed signals
  // ----------------------------------------
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic por = 1'b1;
  logic psel = 1'b0;
  logic pen = 1'b0;
  logic pwr = 1'b0;
  logic [11:0] pad = 12'h000;
  logic [31:0] pwd = 32'h0000_0000;
  logic [3:0] pst = 4'h0;
  logic [5:0] cause = 6'h00;
  logic lsi_tick = 1'b0;
  logic pll_on = 1'b0;
  logic b17_wr = 1'b0;
  logic b17_val = 1'b0;
  logic ref_tick = 1'b0;
  logic [31:0] prd, rd;
  logic prdy, perr, err, lsi_en, lsi_rdy, pdiv_tick, irq;
  logic [3:0] pdiv;
  logic [3:0] dv [3] = '{4'h0, 4'h2, 4'hF};
  int n_fail = 0;
  int checks_done = 0;
  int cnt;

  initial begin
    forever #4 clk = ~clk;
  end

  rcl_top #(.LSI_STARTUP_TICKS(2)) dut (
    .core_clk_in(clk), .rst_in(rst), .por_in(por),
    .psel_in(psel), .penable_in(pen), .pwrite_in(pwr),
    .paddr_in(pad), .pwdata_in(pwd), .pstrb_in(pst),
    .prdata_out(prd), .pready_out(prdy), .pslverr_out(perr),
    .lowpower_reset_in(cause[5]), .window_watchdog_reset_in(cause[4]),
    .independent_watchdog_reset_in(cause[3]),
    .software_reset_in(cause[2]), .power_on_down_reset_in(cause[1]),
    .external_reset_pin_in(cause[0]), .lsi_tick_in(lsi_tick),
    .pll_enabled_in(pll_on), .cfg_bit17_wr_in(b17_wr),
    .cfg_bit17_val_in(b17_val), .pll_ref_tick_in(ref_tick),
    .lsi_enable_out(lsi_en), .lsi_ready_out(lsi_rdy),
    .prediv_out(pdiv), .prediv_tick_out(pdiv_tick), .irq_out(irq)
  );

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic conclude();
    if (n_fail == 0 && checks_done > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : conclude

  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  // Master waits for pready; only the watchdog ends a hang
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d, input logic [3:0] s);
    int n;
    logic ok;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    pen <= 1'b0;
    pwr <= w;
    pad <= a;
    pwd <= d;
    pst <= s;
    @(posedge clk);
    pen <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (prdy !== 1'b1);
    // At most three waits anywhere, none on the pre-divider register
    ok = (n <= 4) && (a != `RCL_CFGR2_OFF || n == 1);
    chk("pready", 32'h1, {31'h0, ok});
    rd = prd;
    err = perr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask : apb

  task automatic wr(input logic [11:0] a, input logic [31:0] d,
                    input logic [3:0] s);
    apb(1'b1, a, d, s);
  endtask : wr

  task automatic rdc(input string nm, input logic [11:0] a,
                     input logic [31:0] e);
    apb(1'b0, a, 32'h0, 4'h0);
    chk(nm, e, rd);
  endtask : rdc

  task automatic pulse_cause(input logic [5:0] c);
    @(posedge clk);
    cause <= c;
    @(posedge clk);
    cause <= 6'h00;
  endtask : pulse_cause

  task automatic lsi_tk(input int n);
    repeat (n) begin
      @(posedge clk);
      lsi_tick <= 1'b1;
      @(posedge clk);
      lsi_tick <= 1'b0;
    end
    @(negedge clk);
  endtask : lsi_tk

  task automatic ref_tk(input int n);
    repeat (n) begin
      @(posedge clk);
      ref_tick <= 1'b1;
      @(posedge clk);
      ref_tick <= 1'b0;
      @(negedge clk);
      if (pdiv_tick === 1'b1) cnt++;
    end
  endtask : ref_tk

  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial begin
    repeat (20000) @(posedge clk);
    n_fail++;
    conclude();
  end

  initial begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    por <= 1'b0;
    rdc("csr", `RCL_CSR_OFF, 32'h0C00_0000);
    rdc("cfgr2", `RCL_CFGR2_OFF, 32'h0);
    for (int i = 0; i < 6; i++) begin
      wr(`RCL_CSR_OFF, 32'h0100_0000, 4'h8);
      rdc("flag_clr", `RCL_CSR_OFF, 32'h0100_0000);
      wr(`RCL_CSR_OFF, 32'h0, 4'h8);
      pulse_cause(6'h01 << i);
      rdc("flag", `RCL_CSR_OFF, 32'h0400_0000 << i);
    end
    // All-ones except clear and enable: nothing may stick
    wr(`RCL_CSR_OFF, 32'hFEFF_FFFE, 4'hF);
    rdc("reserved", `RCL_CSR_OFF, 32'h8000_0000);
    @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    rdc("sysrst", `RCL_CSR_OFF, 32'h8000_0000);
    @(posedge clk);
    por <= 1'b1;
    repeat (2) @(posedge clk);
    por <= 1'b0;
    rdc("por", `RCL_CSR_OFF, 32'h0C00_0000);
    apb(1'b0, 12'h040, 32'h0, 4'h0);
    chk("slverr", 32'h1, {31'h0, err});
    chk("unmapped", 32'h0, rd);
    // Oscillator start with its interrupt masked
    rdc("irq_stat", `RCL_IRQ_STAT_OFF, 32'h0);
    wr(`RCL_IRQ_MASK_OFF, 32'h0, 4'h1);
    wr(`RCL_CSR_OFF, 32'h1, 4'h1);
    @(negedge clk);
    chk("lsi_en", 32'h1, {31'h0, lsi_en});
    lsi_tk(1);
    chk("rdy_early", 32'h0, {31'h0, lsi_rdy});
    lsi_tk(1);
    chk("rdy_up", 32'h1, {31'h0, lsi_rdy});
    wr(`RCL_CSR_OFF, 32'h1, 4'h1);
    rdc("csr_rdy", `RCL_CSR_OFF, 32'h0C00_0003);
    chk("irq_masked", 32'h0, {31'h0, irq});
    rdc("irq_stat", `RCL_IRQ_STAT_OFF, 32'h1);
    rdc("irq_clr", `RCL_IRQ_STAT_OFF, 32'h0);
    // Oscillator stop with its interrupt unmasked
    wr(`RCL_IRQ_MASK_OFF, 32'h3, 4'h1);
    wr(`RCL_CSR_OFF, 32'h0, 4'h1);
    lsi_tk(2);
    chk("rdy_hold", 32'h1, {31'h0, lsi_rdy});
    lsi_tk(1);
    chk("rdy_down", 32'h0, {31'h0, lsi_rdy});
    repeat (2) @(negedge clk);
    chk("irq_up", 32'h1, {31'h0, irq});
    rdc("irq_stat", `RCL_IRQ_STAT_OFF, 32'h2);
    repeat (2) @(negedge clk);
    chk("irq_down", 32'h0, {31'h0, irq});
    foreach (dv[k]) begin
      wr(`RCL_CFGR2_OFF, {28'h0, dv[k]}, 4'h1);
      rdc("cfgr2", `RCL_CFGR2_OFF, {28'h0, dv[k]});
      cnt = 0;
      for (int i = 0; i < 17 && cnt == 0; i++) ref_tk(1);
      cnt = 0;
      ref_tk(48);
      chk("div_ticks", 48 / (dv[k] + 1), cnt);
    end
    @(posedge clk);
    pll_on <= 1'b1;
    wr(`RCL_CFGR2_OFF, 32'h3, 4'h1);
    rdc("locked", `RCL_CFGR2_OFF, 32'hF);
    @(posedge clk);
    pll_on <= 1'b0;
    b17_wr <= 1'b1;
    b17_val <= 1'b0;
    @(posedge clk);
    b17_wr <= 1'b0;
    @(negedge clk);
    chk("prediv", 32'hE, {28'h0, pdiv});
    rdc("cfgr2_b17", `RCL_CFGR2_OFF, 32'hE);
    conclude();
  end
endmodule : rcl_top_bench
